// ==== verilog/pump_flow_pkg.sv ====
// Shared constants and carrier types for the pump flow, mode and trip logic
package pump_flow_pkg;

  localparam int          NUM_PUMPS    = 10;
  localparam int          SPEED_W      = 8;
  localparam int          FLOW_W       = 16;
  localparam int          TEMP_W       = 10;
  localparam int          DELAY_W      = 16;
  localparam int          IDX_W        = 4;
  // Speeds in percent of rated
  localparam logic [7:0]  SPEED_ZERO   = 8'h00;
  localparam logic [7:0]  SPEED_MIN    = 8'h1E;
  localparam logic [7:0]  SPEED_MAX    = 8'h64;
  // Largest allowed bottom-to-saturation gap, degrees C
  localparam logic [9:0]  TEMP_MARGIN  = 10'h050;
  localparam int          VOTE_4_NEED  = 2;
  localparam int          VOTE_3_NEED  = 2;
  localparam int          NUM_CHANNELS = 3;
  // Pumps 0-3 are fed straight from the medium voltage buses
  localparam logic [9:0]  GROUP1_MASK  = 10'h00F;
  localparam logic [9:0]  GROUP2A_MASK = 10'h070;
  localparam logic [9:0]  GROUP2B_MASK = 10'h380;
  localparam logic [9:0]  NO_PUMPS     = 10'h000;
  localparam logic [15:0] DELAY_ZERO   = 16'h0000;
  localparam logic [15:0] DELAY_ONE    = 16'h0001;

  typedef enum logic [1:0] {
    MODE_LOAD_FOLLOW,
    MODE_FLOW_HOLD,
    MODE_MAN_INDIV,
    MODE_MAN_GANG
  } mode_t;

  typedef logic [NUM_PUMPS-1:0][SPEED_W-1:0] speed_vec_t;

  typedef struct packed {
    mode_t                     mode;
    logic                      master_auto;
    logic                      flow_auto;
    logic signed [FLOW_W-1:0]  load_err;
    logic        [FLOW_W-1:0]  flow_setpoint;
    logic        [FLOW_W-1:0]  core_flow;
    speed_vec_t                console_speed;
    logic        [SPEED_W-1:0] gang_speed;
    logic [NUM_PUMPS-1:0]      gang_assign;
    logic [NUM_PUMPS-1:0]      start_select;
    logic                      start_req;
    logic [NUM_PUMPS-1:0]      at_min;
    logic        [TEMP_W-1:0]  bottom_temp;
    logic        [TEMP_W-1:0]  sat_temp;
    logic                      trip_reset;
    logic        [DELAY_W-1:0] l2_delay;
  } op_in_t;

  typedef struct packed {
    logic [3:0] eoc;
    logic [2:0] high_press;
    logic [2:0] level3;
    logic [3:0] level2;
  } trip_in_t;

endpackage : pump_flow_pkg

// ==== verilog/pump_flow_ctrl.sv ====
// Mode control, pump startup sequencing and voted pump trip logic
//
// Contract
// - Operator selects load following, flow holding, individual or collective manual mode.
// - Load following turns load error into flow demand until both errors vanish.
// - Flow loop automatic state does not depend on the master controller.
// - Flow holding compares core flow feedback with the operator flow setpoint.
// - Individual manual passes each console speed, clamped to 30-100 percent, to its drive.
// - Collective manual sets the common speed on assigned pumps only.
// - Idle pump start blocked unless bottom temperature within 80 C of saturation.
// - Startup brings pumps up one at a time to 30 percent speed.
// - All pumps held at minimum until every selected pump reached minimum.
// - Confirmed turbine trip, high pressure or level 3 trips four pumps.
// - First trip group is the four pumps fed directly from the buses.
// - Turbine trip confirmed by two of four channels.
// - High pressure and level 3 each confirmed by two of three.
// - Any one confirmed condition alone starts the first group trip.
// - Trip commands the drives to trip their thyristor inverter stages.
// - Voting is computed in three redundant channels, then majority voted.
// - Level 2 after group one trips three pumps now, three after delay.
// - Level 2 confirmed by two of four channels.
// - Abnormal conditions raise runback, pump trip, rod block and rod insertion.
`timescale 1ns/100ps
module pump_flow_ctrl
  import pump_flow_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire op_in_t               op_in,
  input  wire trip_in_t             trip_in,
  output speed_vec_t                speed_demand,
  output logic [NUM_PUMPS-1:0]      inverter_trip,
  output logic [FLOW_W-1:0]         flow_demand,
  output logic                      startup_busy,
  output logic                      startup_blocked,
  output logic                      runback,
  output logic                      rod_block,
  output logic                      rod_insert
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PICK, SEQ_WAIT} seq_t;

  function automatic logic vote_2oo4(input logic [3:0] ch);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++) n += int'(ch[i]);
    return n >= VOTE_4_NEED;
  endfunction : vote_2oo4

  function automatic logic vote_2oo3(input logic [2:0] ch);
    int n;
    n = 0;
    for (int i = 0; i < 3; i++) n += int'(ch[i]);
    return n >= VOTE_3_NEED;
  endfunction : vote_2oo3

  function automatic logic [SPEED_W-1:0] clamp_speed(input logic [SPEED_W-1:0] s);
    if (s < SPEED_MIN) return SPEED_MIN;
    if (s > SPEED_MAX) return SPEED_MAX;
    return s;
  endfunction : clamp_speed

  // Two-stage input synchronisers; only stage two is read by logic
  op_in_t   op_s1_reg, op_reg;
  trip_in_t trip_s1_reg, trip_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      op_s1_reg   <= '0;
      op_reg      <= '0;
      trip_s1_reg <= '0;
      trip_reg    <= '0;
    end else begin
      op_s1_reg   <= op_in;
      op_reg      <= op_s1_reg;
      trip_s1_reg <= trip_in;
      trip_reg    <= trip_s1_reg;
    end
  end

  // Trip confirmation, one copy per processing channel
  logic [NUM_CHANNELS-1:0] ch_first, ch_level2;
  logic                    eoc_conf, hp_conf, l3_conf, l2_conf;
  logic                    first_conf, level2_conf;

  always_comb begin
    eoc_conf = vote_2oo4(trip_reg.eoc);
    hp_conf  = vote_2oo3(trip_reg.high_press);
    l3_conf  = vote_2oo3(trip_reg.level3);
    l2_conf  = vote_2oo4(trip_reg.level2);
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      ch_first[c]  = eoc_conf | hp_conf | l3_conf;
      ch_level2[c] = l2_conf;
    end
    // Identical copies here, but the majority keeps the channel structure
    first_conf  = vote_2oo3(ch_first);
    level2_conf = vote_2oo3(ch_level2);
  end

  // Latched trips and the delay before the last three pumps
  logic [NUM_PUMPS-1:0] trip_reg_q, trip_next;
  logic [DELAY_W-1:0]   delay_cnt_reg, delay_cnt_next;
  logic                 runback_reg, runback_next;
  logic                 rod_block_reg, rod_block_next;
  logic                 rod_insert_reg, rod_insert_next;

  always_comb begin
    trip_next      = trip_reg_q;
    delay_cnt_next = delay_cnt_reg;
    if (first_conf)
      trip_next = trip_next | GROUP1_MASK;
    if (level2_conf && ((trip_reg_q & GROUP1_MASK) == GROUP1_MASK))
      trip_next = trip_next | GROUP2A_MASK;
    if ((trip_reg_q & GROUP2A_MASK) == GROUP2A_MASK
        && (trip_reg_q & GROUP2B_MASK) != GROUP2B_MASK) begin
      if (delay_cnt_reg >= op_reg.l2_delay)
        trip_next = trip_next | GROUP2B_MASK;
      else
        delay_cnt_next = delay_cnt_reg + DELAY_ONE;
    end
    // A reset loses to a condition that is still confirmed
    if (op_reg.trip_reset && !first_conf && !level2_conf) begin
      trip_next      = NO_PUMPS;
      delay_cnt_next = DELAY_ZERO;
    end
    runback_next    = first_conf | level2_conf;
    rod_block_next  = first_conf | level2_conf | (|trip_reg_q);
    rod_insert_next = first_conf;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trip_reg_q     <= NO_PUMPS;
      delay_cnt_reg  <= DELAY_ZERO;
      runback_reg    <= 1'b0;
      rod_block_reg  <= 1'b0;
      rod_insert_reg <= 1'b0;
    end else begin
      trip_reg_q     <= trip_next;
      delay_cnt_reg  <= delay_cnt_next;
      runback_reg    <= runback_next;
      rod_block_reg  <= rod_block_next;
      rod_insert_reg <= rod_insert_next;
    end
  end

  // Startup sequencer
  seq_t                 seq_reg, seq_next;
  logic [NUM_PUMPS-1:0] running_reg, running_next;
  logic [IDX_W-1:0]     cur_reg, cur_next;
  logic                 busy_reg, busy_next;
  logic                 blocked_reg, blocked_next;
  logic                 temp_ok;
  logic [TEMP_W-1:0]    temp_gap;
  logic [NUM_PUMPS-1:0] pending;

  always_comb begin
    temp_gap = (op_reg.sat_temp >= op_reg.bottom_temp)
             ? op_reg.sat_temp - op_reg.bottom_temp
             : op_reg.bottom_temp - op_reg.sat_temp;
    temp_ok  = temp_gap <= TEMP_MARGIN;
    pending  = op_reg.start_select & ~running_reg & ~trip_reg_q;
    seq_next     = seq_reg;
    running_next = running_reg & ~trip_reg_q;
    cur_next     = cur_reg;
    busy_next    = busy_reg;
    blocked_next = blocked_reg;
    unique case (seq_reg)
      SEQ_IDLE: begin
        if (op_reg.start_req) begin
          seq_next  = SEQ_PICK;
          busy_next = 1'b1;
        end
      end
      SEQ_PICK: begin
        if (pending == NO_PUMPS) begin
          seq_next  = SEQ_IDLE;
          busy_next = 1'b0;
        end else if (!temp_ok) begin
          blocked_next = 1'b1;
        end else begin
          blocked_next = 1'b0;
          for (int i = NUM_PUMPS - 1; i >= 0; i--) begin
            if (pending[i])
              cur_next = IDX_W'(i);
          end
          seq_next = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        // One pump at a time, next only once this one sits at minimum or has tripped
        running_next[cur_reg] = ~trip_reg_q[cur_reg];
        if (op_reg.at_min[cur_reg] || trip_reg_q[cur_reg])
          seq_next = SEQ_PICK;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq_reg     <= SEQ_IDLE;
      running_reg <= NO_PUMPS;
      cur_reg     <= '0;
      busy_reg    <= 1'b0;
      blocked_reg <= 1'b0;
    end else begin
      seq_reg     <= seq_next;
      running_reg <= running_next;
      cur_reg     <= cur_next;
      busy_reg    <= busy_next;
      blocked_reg <= blocked_next;
    end
  end

  // Flow loops and speed demands
  logic [FLOW_W-1:0]  flow_dem_reg, flow_dem_next;
  logic [SPEED_W-1:0] loop_speed_reg, loop_speed_next;
  speed_vec_t         speed_reg, speed_next;
  logic               flow_high, flow_low;

  always_comb begin
    flow_dem_next   = flow_dem_reg;
    loop_speed_next = loop_speed_reg;
    unique case (op_reg.mode)
      MODE_LOAD_FOLLOW: begin
        if (op_reg.master_auto && op_reg.load_err > 0)
          flow_dem_next = flow_dem_reg + 16'h0001;
        else if (op_reg.master_auto && op_reg.load_err < 0 && flow_dem_reg != '0)
          flow_dem_next = flow_dem_reg - 16'h0001;
      end
      MODE_FLOW_HOLD: flow_dem_next = op_reg.flow_setpoint;
      default: ;
    endcase
    flow_high = op_reg.core_flow > flow_dem_reg;
    flow_low  = op_reg.core_flow < flow_dem_reg;
    // Flow loop runs on its own enable, whatever the master does
    if (op_reg.flow_auto && !busy_reg
        && (op_reg.mode == MODE_LOAD_FOLLOW || op_reg.mode == MODE_FLOW_HOLD)) begin
      if (flow_low && loop_speed_reg < SPEED_MAX)
        loop_speed_next = loop_speed_reg + 8'h01;
      else if (flow_high && loop_speed_reg > SPEED_MIN)
        loop_speed_next = loop_speed_reg - 8'h01;
    end
    speed_next = speed_reg;
    for (int i = 0; i < NUM_PUMPS; i++) begin
      if (trip_reg_q[i] || !running_next[i]) begin
        speed_next[i] = SPEED_ZERO;
      end else if (busy_reg) begin
        // Higher speed would overdrive a drive still facing start load
        speed_next[i] = SPEED_MIN;
      end else begin
        unique case (op_reg.mode)
          MODE_MAN_INDIV: speed_next[i] = clamp_speed(op_reg.console_speed[i]);
          MODE_MAN_GANG:
            if (op_reg.gang_assign[i])
              speed_next[i] = clamp_speed(op_reg.gang_speed);
          default:
            if (op_reg.flow_auto)
              speed_next[i] = loop_speed_reg;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flow_dem_reg   <= '0;
      loop_speed_reg <= SPEED_MIN;
      speed_reg      <= '0;
    end else begin
      flow_dem_reg   <= flow_dem_next;
      loop_speed_reg <= loop_speed_next;
      speed_reg      <= speed_next;
    end
  end

  assign speed_demand    = speed_reg;
  assign inverter_trip   = trip_reg_q;
  assign flow_demand     = flow_dem_reg;
  assign startup_busy    = busy_reg;
  assign startup_blocked = blocked_reg;
  assign runback         = runback_reg;
  assign rod_block       = rod_block_reg;
  assign rod_insert      = rod_insert_reg;

  // Checks
  sequence s_group1_down;
    (trip_reg_q & GROUP1_MASK) == GROUP1_MASK;
  endsequence
  sequence s_level2_after_first;
    level2_conf && (trip_reg_q & GROUP1_MASK) == GROUP1_MASK;
  endsequence
  sequence s_start_held;
    busy_reg && running_reg[1] && !trip_reg_q[1] ##1 running_reg[1] && !trip_reg_q[1];
  endsequence

  property p_first_trip;
    @(posedge core_clk) disable iff (!rst_n)
      first_conf |=> s_group1_down;
  endproperty
  a_first_trip: assert property (p_first_trip) else $error("group one not tripped");
  property p_eoc_vote;
    @(posedge core_clk) disable iff (!rst_n)
      ($countones(trip_reg.eoc) >= 2) |=> s_group1_down;
  endproperty
  a_eoc_vote: assert property (p_eoc_vote) else $error("two of four eoc ignored");
  property p_hp_vote;
    @(posedge core_clk) disable iff (!rst_n)
      ($countones(trip_reg.high_press) == 1 && $countones(trip_reg.level3) < 2
       && $countones(trip_reg.eoc) < 2 && trip_reg_q == NO_PUMPS && !level2_conf)
      |=> trip_reg_q == NO_PUMPS;
  endproperty
  a_hp_vote: assert property (p_hp_vote) else $error("single channel tripped pumps");

  property p_level2_now;
    @(posedge core_clk) disable iff (!rst_n)
      s_level2_after_first |=> (trip_reg_q & GROUP2A_MASK) == GROUP2A_MASK;
  endproperty
  a_level2_now: assert property (p_level2_now) else $error("level two group late");
  property p_last_after_delay;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(trip_reg_q[7]) |-> $past(trip_reg_q[4]) && trip_reg_q[0];
  endproperty
  a_last_after_delay: assert property (p_last_after_delay) else $error("last group early");

  property p_trip_latched;
    @(posedge core_clk) disable iff (!rst_n)
      trip_reg_q[0] && !op_reg.trip_reset |=> trip_reg_q[0];
  endproperty
  a_trip_latched: assert property (p_trip_latched) else $error("trip dropped");

  property p_tripped_still;
    @(posedge core_clk) disable iff (!rst_n)
      trip_reg_q[2] |=> speed_reg[2] == SPEED_ZERO;
  endproperty
  a_tripped_still: assert property (p_tripped_still) else $error("tripped pump driven");

  property p_start_hold;
    @(posedge core_clk) disable iff (!rst_n)
      s_start_held |-> speed_reg[1] == SPEED_MIN;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("speed raised during start");

  property p_temp_block;
    @(posedge core_clk) disable iff (!rst_n)
      seq_reg == SEQ_PICK && !temp_ok |=> seq_reg != SEQ_WAIT;
  endproperty
  a_temp_block: assert property (p_temp_block) else $error("start despite temperature");

  property p_one_at_a_time;
    @(posedge core_clk) disable iff (!rst_n)
      $countones(running_reg & ~$past(running_reg)) <= 1;
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time) else $error("two pumps started");

  property p_gang_only;
    @(posedge core_clk) disable iff (!rst_n)
      op_reg.mode == MODE_MAN_GANG && !op_reg.gang_assign[3] && !busy_reg
      && running_next[3] && running_reg[3] && !trip_reg_q[3] |=> $stable(speed_reg[3]);
  endproperty
  a_gang_only: assert property (p_gang_only) else $error("unassigned pump moved");

  property p_indiv_pass;
    @(posedge core_clk) disable iff (!rst_n)
      op_reg.mode == MODE_MAN_INDIV && !busy_reg && running_next[5] && !trip_reg_q[5]
      |=> speed_reg[5] == clamp_speed($past(op_reg.console_speed[5]));
  endproperty
  a_indiv_pass: assert property (p_indiv_pass) else $error("console speed not passed");

endmodule : pump_flow_ctrl

// ==== verification/drive_plant_model.sv ====
// Behavioural model of the ten speed drives answering the flow controller
`timescale 1ns/100ps
module drive_plant_model
  import pump_flow_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 slow,
  input  wire speed_vec_t           speed_demand,
  input  wire logic [NUM_PUMPS-1:0] inverter_trip,
  output logic [NUM_PUMPS-1:0]      at_min
);
  logic [3:0] ramp_reg [NUM_PUMPS];

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_PUMPS; i++) begin
      // A tripped inverter stage drops the motor at once
      if (!rst_n || inverter_trip[i] || speed_demand[i] < SPEED_MIN) begin
        ramp_reg[i] <= 4'h0;
        at_min[i]   <= 1'b0;
      end else begin
        if (ramp_reg[i] != 4'hF) begin
          ramp_reg[i] <= ramp_reg[i] + 4'h1;
        end
        // Slow drives make the sequencer wait longer at each pump
        at_min[i] <= (ramp_reg[i] >= (slow ? 4'hC : 4'h2));
      end
    end
  end
endmodule : drive_plant_model

// ==== verification/pump_flow_ctrl_tb_top.sv ====
// Self-checking bench for the pump flow, mode and trip logic
`timescale 1ns/100ps
module pump_flow_ctrl_tb_top;
  import pump_flow_pkg::*;
  logic                 core_clk;
  logic                 rst_n;
  logic                 slow;
  op_in_t               op_reg;
  op_in_t               op_w;
  trip_in_t             trip_reg;
  speed_vec_t           speed_demand;
  logic [NUM_PUMPS-1:0] inverter_trip;
  logic [NUM_PUMPS-1:0] at_min;
  logic [FLOW_W-1:0]    flow_demand;
  logic                 startup_busy;
  logic                 startup_blocked;
  logic                 runback;
  logic                 rod_block;
  logic                 rod_insert;
  int                   err_count;
  int                   cmp_count;

  always_comb begin
    op_w        = op_reg;
    op_w.at_min = at_min;
  end

  pump_flow_ctrl u_pump_flow_ctrl (.core_clk(core_clk), .rst_n(rst_n), .op_in(op_w),
    .trip_in(trip_reg), .speed_demand(speed_demand), .inverter_trip(inverter_trip),
    .flow_demand(flow_demand), .startup_busy(startup_busy), .startup_blocked(startup_blocked),
    .runback(runback), .rod_block(rod_block), .rod_insert(rod_insert));

  drive_plant_model u_drive_plant_model (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
    .speed_demand(speed_demand), .inverter_trip(inverter_trip), .at_min(at_min));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_val(name, {15'h0000, exp}, {15'h0000, got});
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // Gap of 81 degrees must refuse, 80 must let the sequence run
  task automatic t_startup();
    int n_prev;
    int n_now;
    int guard;
    op_reg.start_req = 1'b1;
    cyc(8);
    chk_bit("startup_blocked", 1'b1, startup_blocked);
    chk_val("speed0 blocked", 16'h0000, {8'h00, speed_demand[0]});
    op_reg.bottom_temp = 10'h0DC;
    guard = 0;
    while (startup_busy !== 1'b1 && guard < 20) begin
      cyc(1);
      guard++;
    end
    chk_bit("startup_busy", 1'b1, startup_busy);
    n_prev = 0;
    while (startup_busy === 1'b1 && guard < 2000) begin
      n_now = 0;
      for (int i = 0; i < NUM_PUMPS; i++) begin
        if (speed_demand[i] > SPEED_MIN) begin
          chk_val("held speed", {8'h00, SPEED_MIN}, {8'h00, speed_demand[i]});
        end
        if (speed_demand[i] == SPEED_MIN) begin
          n_now++;
        end
      end
      if (n_now > n_prev + 1) begin
        chk_val("pumps raised at once", 16'(n_prev + 1), 16'(n_now));
      end
      n_prev = n_now;
      cyc(1);
      guard++;
    end
    chk_val("pumps at minimum", 16'h000A, 16'(n_prev));
    chk_bit("blocked cleared", 1'b0, startup_blocked);
    op_reg.start_req = 1'b0;
    cyc(4);
    chk_val("indiv clamp low", 16'h001E, {8'h00, speed_demand[0]});
    chk_val("indiv pass", 16'h0032, {8'h00, speed_demand[1]});
    chk_val("indiv clamp high", 16'h0064, {8'h00, speed_demand[2]});
  endtask : t_startup

  task automatic t_gang();
    op_reg.gang_assign = 10'h0F0;
    op_reg.gang_speed  = 8'h50;
    op_reg.mode        = MODE_MAN_GANG;
    cyc(5);
    chk_val("gang pump4", 16'h0050, {8'h00, speed_demand[4]});
    chk_val("gang pump7", 16'h0050, {8'h00, speed_demand[7]});
    chk_val("unassigned pump1", 16'h0032, {8'h00, speed_demand[1]});
    chk_val("unassigned pump8", 16'h0032, {8'h00, speed_demand[8]});
  endtask : t_gang

  task automatic t_auto();
    logic [15:0] d0;
    logic [7:0]  s0;
    op_reg.flow_setpoint = 16'h1234;
    op_reg.core_flow     = 16'h0100;
    op_reg.flow_auto     = 1'b1;
    op_reg.mode          = MODE_FLOW_HOLD;
    cyc(6);
    chk_val("flow hold demand", 16'h1234, flow_demand);
    s0 = speed_demand[9];
    cyc(5);
    chk_val("flow loop speed", 16'h0005, {8'h00, speed_demand[9] - s0});
    op_reg.mode        = MODE_LOAD_FOLLOW;
    op_reg.master_auto = 1'b1;
    op_reg.load_err    = 16'sh0064;
    cyc(4);
    d0 = flow_demand;
    cyc(10);
    chk_val("load follow step", 16'h000A, flow_demand - d0);
    op_reg.load_err = 16'sh0000;
    cyc(4);
    d0 = flow_demand;
    cyc(5);
    chk_val("zero error holds", d0, flow_demand);
    op_reg.master_auto = 1'b0;
    op_reg.load_err    = 16'sh0064;
    cyc(4);
    d0 = flow_demand;
    s0 = speed_demand[9];
    cyc(5);
    chk_val("master manual holds", d0, flow_demand);
    chk_val("flow loop stays auto", 16'h0005, {8'h00, speed_demand[9] - s0});
  endtask : t_auto

  // One channel must be ignored, two confirm; reset loses to an active condition
  task automatic trip_case(input trip_in_t one, input trip_in_t two);
    trip_reg = one;
    cyc(5);
    chk_val("single channel", 16'h0000, {6'h00, inverter_trip});
    trip_reg = two;
    cyc(4);
    chk_val("first group", {6'h00, GROUP1_MASK}, {6'h00, inverter_trip});
    chk_bit("runback", 1'b1, runback);
    chk_bit("rod_insert", 1'b1, rod_insert);
    chk_bit("rod_block", 1'b1, rod_block);
    chk_val("tripped speed", 16'h0000, {8'h00, speed_demand[0]});
    trip_reg = '0;
    cyc(5);
    chk_val("trip latched", {6'h00, GROUP1_MASK}, {6'h00, inverter_trip});
    chk_bit("runback gone", 1'b0, runback);
    chk_bit("rod_block held", 1'b1, rod_block);
    trip_reg = two;
    op_reg.trip_reset = 1'b1;
    cyc(4);
    chk_val("reset under trip", {6'h00, GROUP1_MASK}, {6'h00, inverter_trip});
    trip_reg = '0;
    cyc(5);
    chk_val("trip cleared", 16'h0000, {6'h00, inverter_trip});
    chk_bit("runback off", 1'b0, runback);
    chk_bit("rod_block off", 1'b0, rod_block);
    chk_bit("rod_insert off", 1'b0, rod_insert);
    op_reg.trip_reset = 1'b0;
    cyc(2);
  endtask : trip_case

  task automatic t_level2();
    int cnt;
    trip_reg = '{4'h0, 3'h0, 3'h0, 4'h5};
    cyc(6);
    chk_val("level2 alone", 16'h0000, {6'h00, inverter_trip});
    chk_bit("level2 runback", 1'b1, runback);
    chk_bit("level2 no rod_insert", 1'b0, rod_insert);
    trip_reg = '{4'h0, 3'h3, 3'h0, 4'h1};
    cyc(6);
    chk_val("level2 one channel", {6'h00, GROUP1_MASK}, {6'h00, inverter_trip});
    trip_reg = '{4'h0, 3'h3, 3'h0, 4'h5};
    cnt = 0;
    while (inverter_trip[4] !== 1'b1 && cnt < 20) begin
      cyc(1);
      cnt++;
    end
    chk_val("level2 immediate", {6'h00, GROUP1_MASK | GROUP2A_MASK}, {6'h00, inverter_trip});
    cnt = 0;
    while (inverter_trip[7] !== 1'b1 && cnt < 100) begin
      cyc(1);
      cnt++;
    end
    chk_val("delayed trip gap", op_reg.l2_delay + DELAY_ONE, 16'(cnt));
    chk_val("all tripped", 16'h03FF, {6'h00, inverter_trip});
  endtask : t_level2

  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_n     = 1'b0;
    slow      = 1'b1;
    trip_reg  = '0;
    op_reg    = '0;
    op_reg.mode         = MODE_MAN_INDIV;
    op_reg.start_select = 10'h3FF;
    op_reg.sat_temp     = 10'h12C;
    op_reg.bottom_temp  = 10'h0DB;
    op_reg.l2_delay     = 16'h0005;
    for (int i = 0; i < NUM_PUMPS; i++) begin
      op_reg.console_speed[i] = 8'h32;
    end
    op_reg.console_speed[0] = 8'h0A;
    op_reg.console_speed[2] = 8'h70;
    cyc(5);
    chk_val("reset trip", 16'h0000, {6'h00, inverter_trip});
    chk_bit("reset busy", 1'b0, startup_busy);
    rst_n = 1'b1;
    cyc(3);
    t_startup();
    t_gang();
    t_auto();
    slow = 1'b0;
    trip_case('{4'h8, 3'h0, 3'h0, 4'h0}, '{4'h9, 3'h0, 3'h0, 4'h0});
    trip_case('{4'h0, 3'h4, 3'h0, 4'h0}, '{4'h0, 3'h5, 3'h0, 4'h0});
    trip_case('{4'h0, 3'h0, 3'h2, 4'h0}, '{4'h0, 3'h0, 3'h6, 4'h0});
    t_level2();
    end_sim();
  end

  // Whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
endmodule : pump_flow_ctrl_tb_top
